//--- shared/almu_pkg.sv
package almu_pkg;

    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [2:0] MULTI_CYCLES = 3'h2;

    // Flag bit positions in the flag vector
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_W = 6;

    typedef enum logic [4:0] {
        ALMU_ADD = 5'h00,
        ALMU_ADD_CARRY = 5'h01,
        ALMU_SUB = 5'h02,
        ALMU_BORROW_IN_DIFFERENCE = 5'h03,
        ALMU_CONSTANT_DIFFERENCE = 5'h04,
        ALMU_CONSTANT_BORROW_DIFFERENCE = 5'h05,
        ALMU_WORD_IMMEDIATE_ADD = 5'h06,
        ALMU_WORD_IMMEDIATE_SUBTRACT = 5'h07,
        ALMU_AND = 5'h08,
        ALMU_CONSTANT_CONJUNCTION = 5'h09,
        ALMU_OR = 5'h0A,
        ALMU_CONSTANT_DISJUNCTION = 5'h0B,
        ALMU_EXCLUSIVE_DISJUNCTION = 5'h0C,
        ALMU_ONES_COMPLEMENT = 5'h0D,
        ALMU_ZERO_MINUS_OPERAND = 5'h0E,
        ALMU_BIT_SET_BY_MASK = 5'h0F,
        ALMU_BIT_CLEAR_BY_MASK = 5'h10,
        ALMU_STEP_UP_BY_ONE = 5'h11,
        ALMU_STEP_DOWN_BY_ONE = 5'h12,
        ALMU_SELF_CONJUNCTION_CHECK = 5'h13,
        ALMU_SELF_XOR_ZEROING = 5'h14,
        ALMU_ALL_ONES_LOAD = 5'h15,
        ALMU_UNSIGNED_PRODUCT = 5'h16,
        ALMU_SIGNED_PRODUCT = 5'h17,
        ALMU_MIXED_SIGN_PRODUCT = 5'h18,
        ALMU_FRACTIONAL_UNSIGNED_PRODUCT = 5'h19,
        ALMU_FRACTIONAL_SIGNED_PRODUCT = 5'h1A,
        ALMU_FRACTIONAL_MIXED_PRODUCT = 5'h1B
    } almu_op_t;

    typedef struct packed {
        almu_op_t op;
        logic [7:0] dst;
        logic [7:0] dst_hi;
        logic [7:0] src;
        logic [7:0] flags_in;
    } almu_req_t;

    typedef struct packed {
        logic [15:0] value;
        logic wide;
        logic [7:0] flags;
        logic [7:0] flag_mask;
    } almu_res_t;

    typedef enum logic [1:0] {
        ALMU_IDLE = 2'b01,
        ALMU_SECOND = 2'b10
    } almu_state_t;

endpackage : almu_pkg

//--- core/almu_unit.sv
`timescale 1ns/1ns
// What this block does
// RULE_01: Add registers, optional carry, ZCNVH, one clock
// RULE_02: Subtract register, optional borrow, ZCNVH, one clock
// RULE_03: Subtract constant, optional borrow, ZCNVH, one clock
// RULE_04: Word add immediate, ZCNVS, two clocks
// RULE_05: Word subtract immediate, ZCNVS, two clocks
// RULE_06: Conjunction register or constant, ZNV, one clock
// RULE_07: Disjunction register or constant, ZNV, one clock
// RULE_08: Exclusive disjunction of registers, ZNV, one clock
// RULE_09: Mask set uses disjunction, ZNV, one clock
// RULE_10: Mask clear uses complemented constant, ZNV
// RULE_11: Test conjoins register with itself, ZNV
// RULE_12: Byte products into pair, ZC, two clocks
// RULE_13: Fractional products shifted left, ZC, two clocks
// RULE_14: Step up/down by one, ZNV, one clock
// RULE_15: Complements: ones ZCNV, twos adds H
module almu_unit (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire almu_pkg::almu_req_t req,
    output logic busy,
    output logic done,
    output almu_pkg::almu_res_t res
);

    function automatic logic [8:0] add9(input logic [7:0] a,
            input logic [7:0] b, input logic ci);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction : add9

    function automatic logic [7:0] zn_v0(input logic [7:0] r,
            input logic [7:0] f);
        logic [7:0] o;
        o = f;
        o[almu_pkg::FLAG_Z] = (r == almu_pkg::ALL_ZERO);
        o[almu_pkg::FLAG_N] = r[7];
        o[almu_pkg::FLAG_V] = 1'b0;
        o[almu_pkg::FLAG_S] = r[7];
        zn_v0 = o;
    endfunction : zn_v0

    almu_pkg::almu_state_t state_reg, state_next;
    almu_pkg::almu_res_t res_reg, res_next;
    logic done_reg, busy_reg;
    almu_pkg::almu_req_t hold_reg;

    wire almu_pkg::almu_op_t op = req.op;
    wire [7:0] a = req.dst;
    wire [7:0] b = req.src;
    wire cin = req.flags_in[almu_pkg::FLAG_C];
    wire is_sub = op == almu_pkg::ALMU_SUB
        || op == almu_pkg::ALMU_BORROW_IN_DIFFERENCE
        || op == almu_pkg::ALMU_CONSTANT_DIFFERENCE
        || op == almu_pkg::ALMU_CONSTANT_BORROW_DIFFERENCE;
    wire use_c = op == almu_pkg::ALMU_ADD_CARRY
        || op == almu_pkg::ALMU_BORROW_IN_DIFFERENCE
        || op == almu_pkg::ALMU_CONSTANT_BORROW_DIFFERENCE;
    // Subtraction as a + ~b + ~borrow, carry inverted to mean borrow
    wire [8:0] sum9 = add9(a, is_sub ? ~b : b,
        is_sub ? ~(use_c & cin) : (use_c & cin));
    wire [4:0] half = {1'b0, a[3:0]} + {1'b0, is_sub ? ~b[3:0] : b[3:0]}
        + {4'h0, is_sub ? ~(use_c & cin) : (use_c & cin)};
    wire [7:0] sum = sum9[7:0];
    wire [7:0] bx = is_sub ? ~b : b;
    wire add_v = (a[7] == bx[7]) && (sum[7] != a[7]);
    wire [7:0] neg = almu_pkg::ALL_ZERO - a;
    wire [7:0] inc = a + almu_pkg::ONE_BYTE;
    wire [7:0] dec = a - almu_pkg::ONE_BYTE;
    wire [7:0] clr_val = a & (almu_pkg::ALL_ONES - b);
    wire chain_z = op == almu_pkg::ALMU_BORROW_IN_DIFFERENCE
        || op == almu_pkg::ALMU_CONSTANT_BORROW_DIFFERENCE;
    wire is_mul = op >= almu_pkg::ALMU_UNSIGNED_PRODUCT
        && op <= almu_pkg::ALMU_FRACTIONAL_MIXED_PRODUCT;
    wire is_word = op == almu_pkg::ALMU_WORD_IMMEDIATE_ADD
        || op == almu_pkg::ALMU_WORD_IMMEDIATE_SUBTRACT;

    // Second-cycle datapath works from the held request
    wire [15:0] pair = {hold_reg.dst_hi, hold_reg.dst};
    wire [15:0] kw = {8'h00, hold_reg.src};
    wire word_sub = hold_reg.op == almu_pkg::ALMU_WORD_IMMEDIATE_SUBTRACT;
    wire [16:0] wsum = word_sub ? {1'b0, pair} - {1'b0, kw}
        : {1'b0, pair} + {1'b0, kw};
    wire [15:0] wres = wsum[15:0];
    wire wv = word_sub ? (pair[15] & ~wres[15]) : (~pair[15] & wres[15]);
    wire ha = hold_reg.dst[7];
    wire hb = hold_reg.src[7];
    wire mop_sa = hold_reg.op == almu_pkg::ALMU_SIGNED_PRODUCT
        || hold_reg.op == almu_pkg::ALMU_MIXED_SIGN_PRODUCT
        || hold_reg.op == almu_pkg::ALMU_FRACTIONAL_SIGNED_PRODUCT
        || hold_reg.op == almu_pkg::ALMU_FRACTIONAL_MIXED_PRODUCT;
    wire mop_sb = hold_reg.op == almu_pkg::ALMU_SIGNED_PRODUCT
        || hold_reg.op == almu_pkg::ALMU_FRACTIONAL_SIGNED_PRODUCT;
    wire is_mul_h = hold_reg.op >= almu_pkg::ALMU_UNSIGNED_PRODUCT;
    wire frac = hold_reg.op >= almu_pkg::ALMU_FRACTIONAL_UNSIGNED_PRODUCT;
    wire signed [17:0] pa = {{(10){mop_sa & ha}}, hold_reg.dst};
    wire signed [17:0] pb = {{(10){mop_sb & hb}}, hold_reg.src};
    wire signed [17:0] prod18 = pa * pb;
    wire [15:0] prod = prod18[15:0];
    wire [15:0] mres = frac ? {prod[14:0], 1'b0} : prod; // [RULE_13]

    always_comb begin
        res_next = res_reg;
        res_next.wide = 1'b0;
        res_next.flags = req.flags_in;
        res_next.flag_mask = 8'h00;
        res_next.value = {8'h00, a};
        case (op)
            almu_pkg::ALMU_ADD, almu_pkg::ALMU_ADD_CARRY,
            almu_pkg::ALMU_SUB, almu_pkg::ALMU_BORROW_IN_DIFFERENCE,
            almu_pkg::ALMU_CONSTANT_DIFFERENCE,
            almu_pkg::ALMU_CONSTANT_BORROW_DIFFERENCE: begin
                res_next.value = {8'h00, sum}; // [RULE_01] [RULE_02] [RULE_03]
                res_next.flags = zn_v0(sum, req.flags_in);
                res_next.flags[almu_pkg::FLAG_V] = add_v;
                res_next.flags[almu_pkg::FLAG_S] = sum[7] ^ add_v;
                res_next.flags[almu_pkg::FLAG_C] = sum9[8] ^ is_sub;
                res_next.flags[almu_pkg::FLAG_H] = half[4] ^ is_sub;
                // Chained borrow keeps Z only while result stays zero
                if (chain_z) begin
                    res_next.flags[almu_pkg::FLAG_Z] =
                        (sum == almu_pkg::ALL_ZERO)
                        & req.flags_in[almu_pkg::FLAG_Z];
                end
                res_next.flag_mask = 8'h2F;
            end
            almu_pkg::ALMU_AND, almu_pkg::ALMU_CONSTANT_CONJUNCTION: begin
                res_next.value = {8'h00, a & b}; // [RULE_06]
                res_next.flags = zn_v0(a & b, req.flags_in);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_OR, almu_pkg::ALMU_CONSTANT_DISJUNCTION,
            almu_pkg::ALMU_BIT_SET_BY_MASK: begin
                res_next.value = {8'h00, a | b}; // [RULE_07] [RULE_09]
                res_next.flags = zn_v0(a | b, req.flags_in);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_EXCLUSIVE_DISJUNCTION: begin
                res_next.value = {8'h00, a ^ b}; // [RULE_08]
                res_next.flags = zn_v0(a ^ b, req.flags_in);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_SELF_XOR_ZEROING: begin
                res_next.value = {8'h00, almu_pkg::ALL_ZERO};
                res_next.flags = zn_v0(almu_pkg::ALL_ZERO, req.flags_in);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_BIT_CLEAR_BY_MASK: begin
                res_next.value = {8'h00, clr_val}; // [RULE_10]
                res_next.flags = zn_v0(clr_val, req.flags_in);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_SELF_CONJUNCTION_CHECK: begin
                res_next.value = {8'h00, a & a}; // [RULE_11]
                res_next.flags = zn_v0(a, req.flags_in);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_STEP_UP_BY_ONE: begin
                res_next.value = {8'h00, inc}; // [RULE_14]
                res_next.flags = zn_v0(inc, req.flags_in);
                res_next.flags[almu_pkg::FLAG_V] = (a == 8'h7F);
                res_next.flags[almu_pkg::FLAG_S] = inc[7] ^ (a == 8'h7F);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_STEP_DOWN_BY_ONE: begin
                res_next.value = {8'h00, dec}; // [RULE_14]
                res_next.flags = zn_v0(dec, req.flags_in);
                res_next.flags[almu_pkg::FLAG_V] = (a == 8'h80);
                res_next.flags[almu_pkg::FLAG_S] = dec[7] ^ (a == 8'h80);
                res_next.flag_mask = 8'h1E;
            end
            almu_pkg::ALMU_ONES_COMPLEMENT: begin
                res_next.value = {8'h00, almu_pkg::ALL_ONES - a}; // [RULE_15]
                res_next.flags = zn_v0(almu_pkg::ALL_ONES - a, req.flags_in);
                res_next.flags[almu_pkg::FLAG_C] = 1'b1;
                res_next.flag_mask = 8'h1F;
            end
            almu_pkg::ALMU_ZERO_MINUS_OPERAND: begin
                res_next.value = {8'h00, neg}; // [RULE_15]
                res_next.flags = zn_v0(neg, req.flags_in);
                res_next.flags[almu_pkg::FLAG_V] = (neg == 8'h80);
                res_next.flags[almu_pkg::FLAG_S] = neg[7] ^ (neg == 8'h80);
                res_next.flags[almu_pkg::FLAG_C] = (neg != almu_pkg::ALL_ZERO);
                res_next.flags[almu_pkg::FLAG_H] = neg[3] | a[3];
                res_next.flag_mask = 8'h3F;
            end
            almu_pkg::ALMU_ALL_ONES_LOAD: begin
                res_next.value = {8'h00, almu_pkg::ALL_ONES};
            end
            default: begin
                res_next.value = {8'h00, a};
            end
        endcase
    end

    // Second cycle of word and multiply operations
    almu_pkg::almu_res_t res2;
    always_comb begin
        res2 = res_reg;
        res2.wide = 1'b1;
        res2.flags = hold_reg.flags_in;
        if (is_mul_h) begin
            res2.value = mres; // [RULE_12] [RULE_13]
            res2.flags[almu_pkg::FLAG_Z] = (mres == 16'h0000);
            res2.flags[almu_pkg::FLAG_C] = prod[15];
            res2.flag_mask = 8'h03;
        end else begin
            res2.value = wres; // [RULE_04] [RULE_05]
            res2.flags[almu_pkg::FLAG_Z] = (wres == 16'h0000);
            res2.flags[almu_pkg::FLAG_C] = wsum[16];
            res2.flags[almu_pkg::FLAG_N] = wres[15];
            res2.flags[almu_pkg::FLAG_V] = wv;
            res2.flags[almu_pkg::FLAG_S] = wres[15] ^ wv;
            res2.flag_mask = 8'h1F;
        end
    end

    wire start = req_valid && state_reg == almu_pkg::ALMU_IDLE;
    wire start_multi = start && (is_mul || is_word);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            almu_pkg::ALMU_IDLE: begin
                if (start_multi) begin
                    state_next = almu_pkg::ALMU_SECOND;
                end
            end
            almu_pkg::ALMU_SECOND: begin
                state_next = almu_pkg::ALMU_IDLE;
            end
            default: begin
                state_next = almu_pkg::ALMU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= almu_pkg::ALMU_IDLE;
            res_reg <= '0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
            hold_reg <= '0;
        end else begin
            state_reg <= state_next;
            done_reg <= (start && !start_multi)
                || state_reg == almu_pkg::ALMU_SECOND;
            busy_reg <= start_multi;
            if (start) begin
                hold_reg <= req;
            end
            if (state_reg == almu_pkg::ALMU_SECOND) begin
                res_reg <= res2;
            end else if (start && !start_multi) begin
                res_reg <= res_next;
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign res = res_reg;

endmodule : almu_unit

//--- test/almu_unit_assertions.sv
`timescale 1ns/1ns
module almu_unit_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire almu_pkg::almu_req_t req,
    input wire logic busy,
    input wire logic done,
    input wire almu_pkg::almu_res_t res
);
    wire take = req_valid && !busy;
    wire two = req.op inside {5'h06, 5'h07} || req.op >= 5'h16;
    wire lgc = req.op inside {[5'h08:5'h0C], [5'h0F:5'h10], 5'h13, 5'h14};
    wire no_c = req.op inside {[5'h08:5'h0C], [5'h0F:5'h14]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_single_done: assert property (
        take && !two |=> done && !busy)
        else $error("single op not done after one clock");
    chk_two_clock: assert property (
        take && two |=> busy && !done ##1 done && !busy)
        else $error("two clock op timing wrong");
    chk_busy_cause: assert property (
        busy |-> $past(take) && $past(two))
        else $error("busy without a two clock op");
    // Guard on past reset: flops clear on the reset edge itself
    chk_res_hold: assert property (
        !done && !$past(srst) |-> $stable(res))
        else $error("result moved without done");
    chk_add_sum: assert property (
        take && req.op == 5'h00
        |=> res.value[7:0] == $past(req.dst) + $past(req.src))
        else $error("byte sum wrong");
    chk_carry_mask: assert property (
        take && no_c |=> !res.flag_mask[almu_pkg::FLAG_C])
        else $error("carry touched by logic op");
    chk_logic_v: assert property (
        take && lgc |=> !res.flags[almu_pkg::FLAG_V])
        else $error("overflow not cleared by logic op");
    chk_zero_flag: assert property (
        done && res.flag_mask[almu_pkg::FLAG_Z]
        && res.flags[almu_pkg::FLAG_Z] |-> (res.wide ? res.value == 16'h0000
        : res.value[7:0] == 8'h00))
        else $error("zero flag with nonzero value");
    chk_wide_set: assert property (
        take && two |-> ##2 res.wide)
        else $error("wide not set for pair result");
    chk_frac_shift: assert property (
        take && req.op >= 5'h19 |-> ##2 !res.value[0])
        else $error("fractional product not shifted");
    cover property (take && two);
    cover property (busy && req_valid);
    cover property (take && !two ##1 take);
endmodule : almu_unit_checker

bind almu_unit almu_unit_checker i_almu_unit_checker (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req(req), .busy(busy), .done(done), .res(res));

//--- test/almu_decoder_model.sv
`timescale 1ns/1ns
module almu_decoder_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic issue,
    input wire almu_pkg::almu_req_t issue_req,
    input wire logic done,
    input wire almu_pkg::almu_res_t res,
    output logic req_valid,
    output almu_pkg::almu_req_t req,
    output logic [15:0] pair_reg
);
    assign req_valid = issue;
    assign req = issue_req;
    // Pair one-zero takes every wide result
    always_ff @(posedge clk) begin
        if (srst) begin
            pair_reg <= 16'h0000;
        end else if (done && res.wide) begin
            pair_reg <= res.value;
        end
    end
endmodule : almu_decoder_model

//--- test/test_arith_logic_multiply_unit.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, g); err_count++; end end
module test_arith_logic_multiply_unit;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic issue = 1'b0;
    almu_pkg::almu_req_t issue_req = '0;
    logic req_valid;
    almu_pkg::almu_req_t req;
    logic busy;
    logic done;
    almu_pkg::almu_res_t res;
    logic [15:0] pair_reg;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    almu_unit i_almu_unit (.clk(clk), .srst(srst), .req_valid(req_valid),
        .req(req), .busy(busy), .done(done), .res(res));
    almu_decoder_model i_almu_decoder_model (.clk(clk), .srst(srst),
        .issue(issue), .issue_req(issue_req), .done(done), .res(res),
        .req_valid(req_valid), .req(req), .pair_reg(pair_reg));
    function automatic logic is_two(logic [4:0] op);
        return op inside {5'h06, 5'h07} || op >= 5'h16;
    endfunction : is_two
    // Carry or borrow in bit 16
    function automatic logic [16:0] expect_res(logic [4:0] op,
            logic [7:0] d, logic [7:0] h, logic [7:0] s, logic c);
        logic [8:0] b;
        logic [15:0] m;
        logic [16:0] w;
        b = 9'h000;
        m = 16'h0000;
        w = 17'h00000;
        case (op)
            5'h00: b = d + s;
            5'h01: b = d + s + c;
            5'h02, 5'h04: b = d - s;
            5'h03, 5'h05: b = d - s - c;
            5'h06: w = {h, d} + s;
            5'h07: w = {h, d} - s;
            5'h08, 5'h09: b = d & s;
            5'h0A, 5'h0B, 5'h0F: b = d | s;
            5'h0C: b = d ^ s;
            5'h0D: b = 8'hFF - d;
            5'h0E: b = 9'h000 - d;
            5'h10: b = d & (8'hFF - s);
            5'h11: b = d + 8'h01;
            5'h12: b = d - 8'h01;
            5'h13: b = d;
            5'h14: b = 9'h000;
            5'h15: b = 9'h0FF;
            5'h16, 5'h19: m = d * s;
            5'h17, 5'h1A: m = $signed(d) * $signed(s);
            default: m = $signed(d) * $signed({1'b0, s});
        endcase
        if (op >= 5'h19)
            w = {m[15], m[14:0], 1'b0};
        else if (op >= 5'h16)
            w = {m[15], m};
        else if (!is_two(op))
            w = {b[8], 8'h00, b[7:0]};
        return w;
    endfunction : expect_res
    // Single ops keep issue high so back to back requests are exercised
    task automatic run(logic [4:0] op, logic [7:0] d, logic [7:0] h,
            logic [7:0] s, logic [7:0] f);
        logic [16:0] e;
        logic z;
        int lat;
        logic [4:0] hc;
        logic cu;
        logic n;
        logic [15:0] got;
        e = expect_res(op, d, h, s, f[almu_pkg::FLAG_C]);
        // Half carry from bit 3; borrow from bit 3 for subtracts
        cu = (op inside {5'h01, 5'h03, 5'h05}) & f[almu_pkg::FLAG_C];
        hc = (op <= 5'h01) ? {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cu}
            : {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, cu};
        n = is_two(op) ? e[15] : e[7];
        z = is_two(op) ? e[15:0] == 16'h0000 : e[7:0] == 8'h00;
        if (op inside {5'h03, 5'h05})
            z = z & f[almu_pkg::FLAG_Z];
        lat = 0;
        issue = 1'b1;
        issue_req = '{almu_pkg::almu_op_t'(op), d, h, s, f};
        @(posedge clk) #1;
        if (is_two(op))
            issue = 1'b0;
        while (done !== 1'b1 && lat < 4) begin
            @(posedge clk) #1;
            lat++;
        end
        `CHK("cycles", is_two(op) ? 1 : 0, lat)
        got = is_two(op) ? res.value : {8'h00, res.value[7:0]};
        `CHK("value", e[15:0], got)
        if (op <= 5'h05) begin
            `CHK("half", hc[4], res.flags[almu_pkg::FLAG_H])
        end
        if (op < 5'h15) begin
            `CHK("neg", n, res.flags[almu_pkg::FLAG_N])
        end
        `CHK("wide", is_two(op), res.wide)
        if (op <= 5'h07 || op >= 5'h16) begin
            `CHK("carry", e[16], res.flags[almu_pkg::FLAG_C])
        end
        if (op != 5'h15) begin
            `CHK("zero", z, res.flags[almu_pkg::FLAG_Z])
        end
        if (op inside {[5'h08:5'h0C], [5'h0F:5'h10], 5'h13, 5'h14}) begin
            `CHK("over", 1'b0, res.flags[almu_pkg::FLAG_V])
        end
        if (op inside {[5'h08:5'h0C], [5'h0F:5'h14]}) begin
            `CHK("cmask", 1'b0, res.flag_mask[almu_pkg::FLAG_C])
        end
    endtask : run
    task automatic t_byte_arith;
        run(5'h00, 8'hF8, 8'h00, 8'h08, 8'h00);
        run(5'h01, 8'h7F, 8'h00, 8'h00, 8'h01);
        run(5'h02, 8'h10, 8'h00, 8'h20, 8'h00);
        run(5'h03, 8'h05, 8'h00, 8'h04, 8'h03);
        run(5'h04, 8'h00, 8'h00, 8'h01, 8'h00);
        run(5'h05, 8'h40, 8'h00, 8'h3F, 8'h01);
        issue = 1'b0;
    endtask : t_byte_arith
    task automatic t_logic;
        for (int i = 8; i <= 21; i++) begin
            run(i[4:0], 8'hA5, 8'h00, 8'h3C, 8'h01);
        end
        run(5'h11, 8'hFF, 8'h00, 8'h00, 8'h00);
        run(5'h12, 8'h00, 8'h00, 8'h00, 8'h00);
        run(5'h13, 8'h00, 8'h00, 8'hFF, 8'h00);
        run(5'h0E, 8'h80, 8'h00, 8'h00, 8'h00);
        issue = 1'b0;
    endtask : t_logic
    task automatic t_word;
        run(5'h06, 8'hFF, 8'h00, 8'h01, 8'h00);
        run(5'h06, 8'hFF, 8'hFF, 8'h3F, 8'h00);
        run(5'h07, 8'h00, 8'h00, 8'h01, 8'h00);
        run(5'h07, 8'h00, 8'h01, 8'h3F, 8'h00);
    endtask : t_word
    task automatic t_mult;
        for (int i = 22; i <= 27; i++) begin
            run(i[4:0], 8'h80, 8'h00, 8'hFF, 8'h00);
        end
        run(5'h16, 8'h00, 8'h00, 8'h5A, 8'h00);
        run(5'h16, 8'h0F, 8'h00, 8'h11, 8'h00);
        @(posedge clk) #1;
        `CHK("pair", 16'h00FF, pair_reg)
    endtask : t_mult
    task automatic t_refused;
        issue = 1'b1;
        issue_req = '{almu_pkg::ALMU_UNSIGNED_PRODUCT, 8'h0F, 8'h00, 8'h11,
            8'h00};
        @(posedge clk) #1;
        issue_req.op = almu_pkg::ALMU_ADD;
        `CHK("busy", 1'b1, busy)
        @(posedge clk) #1;
        issue = 1'b0;
        `CHK("done", 1'b1, done)
        `CHK("prod", 16'h00FF, res.value)
        @(posedge clk) #1;
        `CHK("dropped", 1'b0, done)
    endtask : t_refused
    // Reset in the middle of a two clock op must leave nothing behind
    task automatic t_reset;
        issue = 1'b1;
        issue_req = '{almu_pkg::ALMU_SIGNED_PRODUCT, 8'h80, 8'h00, 8'h7F,
            8'h00};
        @(posedge clk) #1;
        issue = 1'b0;
        srst = 1'b1;
        @(posedge clk) #1;
        srst = 1'b0;
        `CHK("rst_busy", 1'b0, busy)
        `CHK("rst_done", 1'b0, done)
        `CHK("rst_res", 33'h0, res)
        @(posedge clk) #1;
        `CHK("rst_idle", 1'b0, done)
        run(5'h00, 8'h01, 8'h00, 8'h02, 8'h00);
        issue = 1'b0;
    endtask : t_reset
    task automatic final_report;
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk) #1;
        t_byte_arith();
        t_logic();
        t_word();
        t_mult();
        t_refused();
        t_reset();
        final_report();
    end
endmodule : test_arith_logic_multiply_unit
